// File: nvsc_consts.svh
// Constants for the nonvolatile SRAM host controller.
// Assumes a 20 MHz core clock and an asynchronous SRAM pin bus.
`ifndef NVSC_CONSTS_SVH
`define NVSC_CONSTS_SVH

`define NVSC_CLK_MHZ          20
// Access timing in ns and derived cycle counts (least times round up)
`define NVSC_T_ACCESS_NS      45
`define NVSC_ACCESS_CYC       ((`NVSC_T_ACCESS_NS * `NVSC_CLK_MHZ + 999) / 1000 + 1)
`define NVSC_T_WP_NS          30
`define NVSC_WP_CYC           ((`NVSC_T_WP_NS * `NVSC_CLK_MHZ + 999) / 1000)
`define NVSC_T_SEL_NS         30
`define NVSC_SEL_CYC          ((`NVSC_T_SEL_NS * `NVSC_CLK_MHZ + 999) / 1000)
// Nonvolatile cycle durations in us
`define NVSC_T_STORE_US       10000
`define NVSC_STORE_CYC        (`NVSC_T_STORE_US * `NVSC_CLK_MHZ)
`define NVSC_T_RECALL_US      20
`define NVSC_RECALL_CYC       (`NVSC_T_RECALL_US * `NVSC_CLK_MHZ)
`define NVSC_T_RESTORE_US     550
`define NVSC_RESTORE_CYC      (`NVSC_T_RESTORE_US * `NVSC_CLK_MHZ)

// Software sequence addresses
`define NVSC_SEQ0             15'h0e38
`define NVSC_SEQ1             15'h31c7
`define NVSC_SEQ2             15'h03e0
`define NVSC_SEQ3             15'h3c1f
`define NVSC_SEQ4             15'h303f
`define NVSC_SEQ_STORE        15'h0fc0
`define NVSC_SEQ_RECALL       15'h0c63

`endif

// File: nvsc_pkg.sv
// Types for the nonvolatile SRAM host controller.
// Assumes nothing beyond the constants header.
package nvsc_pkg;
    typedef enum logic [1:0] {
        NVSC_OP_READ   = 2'h0,
        NVSC_OP_WRITE  = 2'h1,
        NVSC_OP_STORE  = 2'h2,
        NVSC_OP_RECALL = 2'h3
    } nvsc_op_t;

    typedef enum logic [6:0] {
        NVSC_ST_IDLE  = 7'h01,
        NVSC_ST_SETUP = 7'h02,
        NVSC_ST_RD    = 7'h04,
        NVSC_ST_WR    = 7'h08,
        NVSC_ST_GAP   = 7'h10,
        NVSC_ST_WAIT  = 7'h20,
        NVSC_ST_PWRUP = 7'h40
    } nvsc_state_t;
endpackage

// File: nvsc_seq_rom.sv
// Small table of the six-address software sequence.
// Assumes the constants header; output comes from a register.
`timescale 1ns/1ps
`include "nvsc_consts.svh"
module nvsc_seq_rom (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    // Lookup
    input  wire logic [2:0]  index_i,
    input  wire logic        recall_i,
    output logic      [14:0] addr_o
);
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            addr_o <= 15'h0000;
        end else begin
            unique case (index_i)
                3'h0:    addr_o <= `NVSC_SEQ0;
                3'h1:    addr_o <= `NVSC_SEQ1;
                3'h2:    addr_o <= `NVSC_SEQ2;
                3'h3:    addr_o <= `NVSC_SEQ3;
                3'h4:    addr_o <= `NVSC_SEQ4;
                default: addr_o <= recall_i ? `NVSC_SEQ_RECALL : `NVSC_SEQ_STORE;
            endcase
        end
    end
endmodule

// File: nvsc_host.sv
// Host controller driving a nonvolatile SRAM over its parallel pins.
// Assumes one 20 MHz clock; device pins are asynchronous to it.
`timescale 1ns/1ps
`include "nvsc_consts.svh"
module nvsc_host
    import nvsc_pkg::*;
#(
    parameter int unsigned STORE_CYC   = `NVSC_STORE_CYC,
    parameter int unsigned RESTORE_CYC = `NVSC_RESTORE_CYC
) (
    // Clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              reset_n_i,
    // User request
    input  wire logic              req_valid_i,
    input  wire nvsc_pkg::nvsc_op_t req_op_i,
    input  wire logic [14:0]       req_addr_i,
    input  wire logic [7:0]        req_wdata_i,
    output logic                   req_ready_o,
    output logic                   rsp_valid_o,
    output logic [7:0]             rsp_rdata_o,
    output logic                   busy_o,
    // Supply monitor (asynchronous, high when supply above switch level)
    input  wire logic              supply_ok_i,
    // SRAM pins
    output logic [14:0]            sram_addr_o,
    output logic                   sram_chip_sel_n_o,
    output logic                   sram_write_en_n_o,
    output logic                   sram_out_en_n_o,
    input  wire logic [7:0]        sram_data_i,
    output logic [7:0]             sram_data_o,
    output logic                   sram_data_oe_o
);
    import nvsc_pkg::*;

    localparam int unsigned WAIT_W = 24;

    nvsc_state_t     state;
    nvsc_op_t        op;
    logic [2:0]      seq_idx;
    logic [WAIT_W-1:0] timer;
    logic [1:0]      supply_sync;
    logic [7:0]      data_sync0;
    logic [7:0]      data_sync1;
    logic [14:0]     seq_addr;
    logic [2:0]      rom_idx;
    logic            seq_mode;
    logic            supply_ok;

    assign supply_ok = supply_sync[1];
    // Table is registered: fetch the next entry one cycle ahead
    assign rom_idx   = (state == NVSC_ST_GAP)  ? seq_idx + 3'h1 :
                       (state == NVSC_ST_IDLE) ? 3'h0 : seq_idx;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            supply_sync <= 2'h0;
            data_sync0  <= 8'h00;
            data_sync1  <= 8'h00;
        end else begin
            supply_sync <= {supply_sync[0], supply_ok_i};
            data_sync0  <= sram_data_i;
            data_sync1  <= data_sync0;
        end
    end

    nvsc_seq_rom u_seq_rom (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .index_i    (rom_idx),
        .recall_i   (op == NVSC_OP_RECALL),
        .addr_o     (seq_addr)
    );

    function automatic logic is_seq_op(input nvsc_op_t o);
        return (o == NVSC_OP_STORE) || (o == NVSC_OP_RECALL);
    endfunction

    assign seq_mode    = is_seq_op(op);
    // Writes and stores held off while supply low
    assign req_ready_o = (state == NVSC_ST_IDLE) &&
                         (supply_ok || req_op_i == NVSC_OP_READ ||
                          req_op_i == NVSC_OP_RECALL);
    assign busy_o      = (state != NVSC_ST_IDLE);

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state   <= NVSC_ST_PWRUP;
            op      <= NVSC_OP_READ;
            seq_idx <= 3'h0;
            timer   <= '0;
        end else begin
            unique case (state)
                NVSC_ST_PWRUP: begin
                    // Wait out the power-up recall with the part deselected
                    if (!supply_ok) begin
                        timer <= WAIT_W'(RESTORE_CYC);
                    end else if (timer != '0) begin
                        timer <= timer - 1'b1;
                    end else begin
                        state <= NVSC_ST_IDLE;
                    end
                end
                NVSC_ST_IDLE: begin
                    seq_idx <= 3'h0;
                    if (req_valid_i && req_ready_o) begin
                        op    <= req_op_i;
                        state <= NVSC_ST_SETUP;
                    end else if (!supply_ok) begin
                        state <= NVSC_ST_PWRUP;
                    end
                end
                NVSC_ST_SETUP: begin
                    // Address settles before select falls
                    timer <= (op == NVSC_OP_WRITE) ? WAIT_W'(`NVSC_WP_CYC)
                                                   : WAIT_W'(`NVSC_ACCESS_CYC);
                    state <= (op == NVSC_OP_WRITE) ? NVSC_ST_WR : NVSC_ST_RD;
                end
                NVSC_ST_RD, NVSC_ST_WR: begin
                    if (timer != '0) begin
                        timer <= timer - 1'b1;
                    end else begin
                        state <= NVSC_ST_GAP;
                    end
                end
                NVSC_ST_GAP: begin
                    if (seq_mode && seq_idx != 3'h5) begin
                        // Next read of the sequence, back to back
                        seq_idx <= seq_idx + 3'h1;
                        state   <= NVSC_ST_SETUP;
                    end else if (seq_mode) begin
                        timer <= (op == NVSC_OP_STORE) ? WAIT_W'(STORE_CYC)
                                                       : WAIT_W'(`NVSC_RECALL_CYC);
                        state <= NVSC_ST_WAIT;
                    end else begin
                        state <= NVSC_ST_IDLE;
                    end
                end
                NVSC_ST_WAIT: begin
                    // Device ignores all access until cycle completes
                    if (timer != '0) begin
                        timer <= timer - 1'b1;
                    end else begin
                        state <= NVSC_ST_IDLE;
                    end
                end
                default: state <= NVSC_ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sram_addr_o       <= 15'h0000;
            sram_chip_sel_n_o <= 1'b1;
            sram_write_en_n_o <= 1'b1;
            sram_out_en_n_o   <= 1'b1;
            sram_data_o       <= 8'h00;
            sram_data_oe_o    <= 1'b0;
        end else begin
            sram_chip_sel_n_o <= 1'b1;
            sram_write_en_n_o <= 1'b1;
            sram_out_en_n_o   <= 1'b1;
            if (state == NVSC_ST_IDLE && req_valid_i && req_ready_o) begin
                sram_addr_o <= req_addr_i;
                sram_data_o <= req_wdata_i;
            end else if (state == NVSC_ST_SETUP && seq_mode) begin
                sram_addr_o <= seq_addr;
            end
            if (state == NVSC_ST_RD && timer != '0) begin
                // Select-framed read, write enable high, outputs on
                sram_chip_sel_n_o <= 1'b0;
                sram_out_en_n_o   <= 1'b0;
            end
            if (state == NVSC_ST_SETUP && op == NVSC_OP_WRITE && supply_ok) begin
                sram_data_oe_o <= 1'b1;
            end else if (state == NVSC_ST_GAP) begin
                sram_data_oe_o <= 1'b0;
            end
            if (state == NVSC_ST_WR && timer != '0 && supply_ok) begin
                // Output enable stays high for the whole write
                sram_chip_sel_n_o <= 1'b0;
                sram_write_en_n_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data capture
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= 8'h00;
        end else begin
            rsp_valid_o <= 1'b0;
            if (state == NVSC_ST_GAP && op == NVSC_OP_READ) begin
                rsp_valid_o <= 1'b1;
                rsp_rdata_o <= data_sync1;
            end
        end
    end

    AST_NO_WRITE_LOW_SUPPLY: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        !sram_write_en_n_o |-> $past(supply_ok)) else $error("write while supply low");
    AST_WRITE_OE_HIGH: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        !sram_write_en_n_o |-> sram_out_en_n_o && !sram_chip_sel_n_o) else $error("write frame bad");
    AST_SEQ_NO_WRITE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        seq_mode && state != NVSC_ST_IDLE |-> sram_write_en_n_o) else $error("write in sequence");
    AST_ADDR_STABLE_WR: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (!sram_write_en_n_o || $rose(sram_write_en_n_o)) |-> $stable(sram_addr_o))
        else $error("address moved in write");
    AST_ADDR_BEFORE_SEL: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        $fell(sram_chip_sel_n_o) |-> $stable(sram_addr_o)) else $error("address at select");
    AST_DATA_DRIVEN_WR: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        $rose(sram_write_en_n_o) |-> $past(sram_data_oe_o)) else $error("data not driven");
    AST_WAIT_IDLE_PINS: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        state == NVSC_ST_WAIT |-> sram_chip_sel_n_o) else $error("access during nv cycle");
    AST_PWRUP_DESEL: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        state == NVSC_ST_PWRUP |=> sram_chip_sel_n_o && sram_write_en_n_o) else $error("power-up access");
    AST_READ_RSP: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        state == NVSC_ST_GAP && op == NVSC_OP_READ |=> rsp_valid_o) else $error("no read response");
endmodule

// File: nvsc_sram_model.sv
// Behavioural model of the nonvolatile SRAM seen from the host pins.
// Assumes the bench resolves the shared data wire from the host data enable.
`timescale 1ns/1ps
module nvsc_sram_model #(
    parameter int STORE_NS   = 900,
    parameter int RECALL_NS  = 19000,
    parameter int RESTORE_NS = 400
) (
    // Pins
    input  wire logic [14:0] addr_i,
    input  wire logic        cs_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    input  wire logic [7:0]  data_i,
    input  wire logic        supply_ok_i,
    output logic      [7:0]  data_o
);
    logic [7:0]  mem [32768];
    logic [7:0]  nv [32768];
    logic [13:0] seq [6] = '{14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f, 14'h303f, 14'h0fc0};
    logic [7:0]  last_q = 8'h00;
    logic        busy = 1'b0;
    logic        dirty = 1'b0;
    int          idx = 0;
    wire         rd = !cs_n_i && !oe_n_i && we_n_i && !busy;
    wire         wr = !cs_n_i && !we_n_i;
    initial foreach (nv[i]) nv[i] = 8'h00;
    // Released wire shows the inverse of the last value
    always @* data_o = rd ? mem[addr_i] : ~last_q;
    always @(data_o) if (rd) last_q = data_o;
    task automatic nv_run(input bit store, input int ns);
        busy = 1'b1;
        if (!store) foreach (mem[i]) mem[i] = 8'h00;
        #(ns);
        if (store) nv = mem;
        else mem = nv;
        dirty = 1'b0;
        busy = 1'b0;
    endtask
    always @(negedge wr) begin
        idx = 0;
        if (!busy && supply_ok_i) begin
            mem[addr_i] = data_i;
            dirty = 1'b1;
        end
    end
    always @(negedge cs_n_i) if (!busy) begin
        if (!we_n_i) begin
            idx = 0;
        end else if (idx == 5 && addr_i[13:0] == 14'h0c63) begin
            idx = 0;
            fork
                nv_run(1'b0, RECALL_NS);
            join_none
        end else if (idx == 5 && addr_i[13:0] == seq[5] && supply_ok_i) begin
            idx = 0;
            fork
                nv_run(1'b1, STORE_NS);
            join_none
        end else if (idx < 5 && addr_i[13:0] == seq[idx]) begin
            idx = idx + 1;
        end else begin
            idx = (addr_i[13:0] == seq[0]) ? 1 : 0;
        end
    end
    always @(negedge supply_ok_i) if (dirty) begin
        nv = mem;
        dirty = 1'b0;
    end
    always @(posedge supply_ok_i) begin
        fork
            nv_run(1'b0, RESTORE_NS);
        join_none
    end
endmodule

// File: nvsc_host_test.sv
// Self-checking bench for the nonvolatile SRAM host controller.
// Assumes the design files and the device model are compiled first.
`timescale 1ns/1ps
module nvsc_host_test;
    import nvsc_pkg::*;
    logic        core_clk_i;
    logic        reset_n_i = 1'b0;
    logic        req_valid_i = 1'b0;
    nvsc_op_t    req_op_i = NVSC_OP_READ;
    logic [14:0] req_addr_i = 15'h0000;
    logic [7:0]  req_wdata_i = 8'h00;
    logic        supply_ok_i = 1'b0;
    logic        req_ready_o, rsp_valid_o, busy_o, cs_n, we_n, oe_n, d_oe;
    logic [7:0]  rsp_rdata_o, d_out, dev_q, rd_q;
    logic [14:0] sram_addr;
    logic [31:0] seed = 32'h340c0604;
    logic [31:0] r;
    logic [7:0]  ref_mem [32768];
    logic [7:0]  ref_nv [32768];
    int          failures = 0;
    int          cmp_count = 0;
    wire  [7:0]  sram_data_i = d_oe ? d_out : dev_q;
    nvsc_host #(.STORE_CYC(20), .RESTORE_CYC(10)) dut_u (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i),
        .req_op_i(req_op_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
        .busy_o(busy_o), .supply_ok_i(supply_ok_i), .sram_addr_o(sram_addr),
        .sram_chip_sel_n_o(cs_n), .sram_write_en_n_o(we_n), .sram_out_en_n_o(oe_n),
        .sram_data_i(sram_data_i), .sram_data_o(d_out), .sram_data_oe_o(d_oe));
    nvsc_sram_model dev_u (.addr_i(sram_addr), .cs_n_i(cs_n), .we_n_i(we_n), .oe_n_i(oe_n),
        .data_i(sram_data_i), .supply_ok_i(supply_ok_i), .data_o(dev_q));
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] exp_of(input logic [14:0] a);
        return ref_mem[a];
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_for(input bit rsp);
        int n;
        n = 0;
        while ((rsp ? rsp_valid_o !== 1'b1 : busy_o !== 1'b0) && n < 30000) begin
            @(negedge core_clk_i);
            n++;
        end
        if (n == 30000) failures++;
    endtask
    task automatic do_op(input nvsc_op_t op, input logic [14:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        req_valid_i = 1'b1;
        req_op_i = op;
        req_addr_i = a;
        req_wdata_i = d;
        #1;
        while (req_ready_o !== 1'b1) begin
            @(negedge core_clk_i);
            #1;
        end
        @(negedge core_clk_i);
        req_valid_i = 1'b0;
        if (op == NVSC_OP_READ) wait_for(1'b1);
        rd_q = rsp_rdata_o;
        wait_for(1'b0);
    endtask
    task automatic wr_ref(input logic [14:0] a, input logic [7:0] d);
        do_op(NVSC_OP_WRITE, a, d);
        ref_mem[a] = d;
    endtask
    task automatic rd_chk(input logic [14:0] a);
        do_op(NVSC_OP_READ, a, 8'h00);
        check(rd_q, exp_of(a));
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        report_and_stop();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        foreach (ref_mem[i]) ref_mem[i] = 8'h00;
        repeat (8) @(negedge core_clk_i);
        reset_n_i = 1'b1;
        supply_ok_i = 1'b1;
        wait_for(1'b0);
        wr_ref(15'h7fff, 8'ha5);
        wr_ref(15'h3fff, 8'h5a);
        rd_chk(15'h7fff);
        rd_chk(15'h3fff);
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            if (r[31])
                wr_ref({r[14:13], 9'h000, r[3:0]}, r[23:16]);
            else
                rd_chk({r[14:13], 9'h000, r[3:0]});
        end
        $display("test random read write done");
        wr_ref(15'h0123, 8'h3c);
        do_op(NVSC_OP_STORE, 15'h0000, 8'h00);
        ref_nv = ref_mem;
        wr_ref(15'h0123, 8'hc3);
        rd_chk(15'h0123);
        do_op(NVSC_OP_RECALL, 15'h0000, 8'h00);
        ref_mem = ref_nv;
        rd_chk(15'h0123);
        rd_chk(15'h7fff);
        $display("test store recall done");
        wr_ref(15'h0456, 8'h96);
        supply_ok_i = 1'b0;
        ref_nv = ref_mem;
        repeat (2) @(negedge core_clk_i);
        req_op_i = NVSC_OP_WRITE;
        #1;
        check({7'h00, req_ready_o}, 8'h00);
        req_op_i = NVSC_OP_STORE;
        #1;
        check({7'h00, req_ready_o}, 8'h00);
        req_op_i = NVSC_OP_READ;
        #1;
        check({7'h00, req_ready_o}, 8'h01);
        @(negedge core_clk_i);
        supply_ok_i = 1'b1;
        ref_mem = ref_nv;
        repeat (20) @(negedge core_clk_i);
        rd_chk(15'h0456);
        rd_chk(15'h0123);
        $display("test supply loss done");
        report_and_stop();
    end
endmodule
